// ===== scc_pkg.sv
// package: register map, field layouts, reset values and encodings for clock compensation control
package scc_pkg;
  // register byte offsets are word indices (printed offsets not multiples of four)
  localparam logic [11:0] IDX_AUX_SRC = 12'h284;
  localparam logic [11:0] IDX_CL_SEL = 12'h287;
  localparam logic [11:0] IDX_FILT_CUT = 12'h288;
  localparam logic [11:0] IDX_C0_LO = 12'h289;
  localparam logic [11:0] IDX_C0_HI = 12'h28a;
  localparam logic [11:0] IDX_COEF_BASE = 12'h28b;
  localparam logic [11:0] IDX_COMB_SEL = 12'h29a;
  localparam logic [11:0] IDX_NOM_PER = 12'h29b;
  localparam logic [11:0] IDX_STATUS = 12'h29c;
  localparam logic [11:0] IDX_CF1 = 12'h29d;
  localparam logic [11:0] IDX_CF3 = 12'h29e;
  localparam logic [11:0] IDX_COMB = 12'h29f;
  localparam int NUM_COEF = 5;
  localparam int C0_W = 40;
  localparam int SIG_W = 16;
  localparam int EXP_W = 8;
  localparam int EXP_BIAS = 15;
  localparam int C0_SHIFT = 45;
  localparam int CF_W = 32;
  localparam int CF_FRAC = 30;
  localparam logic [CF_W-1:0] CF_ONE = 32'h4000_0000;
  localparam logic [CF_W-1:0] CF_125PPM = 32'h0002_0c4a;
  localparam logic [4:0] SRC_REF_A = 5'h00;
  localparam logic [4:0] SRC_REF_AC = 5'h01;
  localparam logic [4:0] SRC_REF_B0 = 5'h02;
  localparam logic [4:0] SRC_REF_B1 = 5'h03;
  localparam logic [4:0] SRC_AUX0 = 5'h06;
  localparam logic [4:0] SRC_AUX1 = 5'h07;
  localparam logic [4:0] AUX_SRC_RST = 5'h00;
  localparam logic CL_SEL_RST = 1'b0;
  localparam logic [2:0] FILT_RST = 3'h0;
  localparam int FILT_SH0 = 12;
  localparam logic [31:0] NOM_PER_RST = 32'h0000_2710;
  localparam logic [31:0] APB_ERR_DATA = 32'h0000_0000;
  typedef struct packed {
    logic [CF_W-1:0] cf1;
    logic [CF_W-1:0] cf2;
    logic [CF_W-1:0] cf3;
  } scc_cf_t;
  typedef struct packed {
    logic valid;
    logic [4:0] src;
    logic [31:0] period;
  } scc_meas_t;
endpackage

// ===== scc_lpf.sv
// two coincident-pole smoothing filter with automatic bypass
module scc_lpf #(
  parameter int W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic [2:0] i_cut,
  input wire logic i_unstable,
  input wire logic [W-1:0] i_raw,
  output logic [W-1:0] o_out,
  output logic o_bypass
);
  logic signed [W+7:0] p1_r, p1_nxt, p2_r, p2_nxt;
  logic byp_r, byp_nxt;
  logic signed [W+7:0] diff;
  logic [4:0] sh;

  // shift grows by one per code step: bandwidth halves, 156 hz down to 1 hz
  always_comb begin
    sh = 5'(scc_pkg::FILT_SH0) + {2'h0, i_cut};
    diff = $signed({8'h00, i_raw}) - p2_r;
    byp_nxt = i_unstable || (diff > $signed({8'h00, scc_pkg::CF_125PPM}))
      || (-diff > $signed({8'h00, scc_pkg::CF_125PPM}));
    p1_nxt = p1_r;
    p2_nxt = p2_r;
    if (byp_nxt) begin
      // bypass preloads both poles so the filter rejoins without a step
      p1_nxt = $signed({8'h00, i_raw});
      p2_nxt = $signed({8'h00, i_raw});
    end else if (i_tick) begin
      p1_nxt = p1_r + ((($signed({8'h00, i_raw}) - p1_r)) >>> sh);
      p2_nxt = p2_r + ((p1_r - p2_r) >>> sh);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      p1_r <= '0;
      p2_r <= '0;
      byp_r <= 1'b1;
    end else begin
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      byp_r <= byp_nxt;
    end
  end

  assign o_out = W'(p2_r);
  assign o_bypass = byp_r;
endmodule

// ===== scc_top.sv
// system clock compensation control: coefficients, filter, closed-loop factors, apb registers
module scc_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [13:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic signed [15:0] i_temp,
  input wire logic i_temp_tick,
  input wire logic i_sys_unstable,
  input wire logic [scc_pkg::CF_W-1:0] i_main_cf0,
  input wire logic [scc_pkg::CF_W-1:0] i_main_cf1,
  input wire logic [7:0] i_tdc_valid,
  input wire logic [255:0] i_tdc_period,
  input wire logic [scc_pkg::CF_W-1:0] i_aux_incoming,
  output logic [scc_pkg::CF_W-1:0] o_comb_factor,
  output logic [4:0] o_aux_src,
  output logic o_main_sel
);
  // software-visible state
  logic [4:0] aux_src_r, aux_src_nxt;
  logic cl_sel_r, cl_sel_nxt;
  logic [2:0] cut_r, cut_nxt;
  logic [scc_pkg::C0_W-1:0] c0_r, c0_nxt;
  logic [scc_pkg::SIG_W-1:0] sig_r [scc_pkg::NUM_COEF];
  logic [scc_pkg::SIG_W-1:0] sig_nxt [scc_pkg::NUM_COEF];
  logic [scc_pkg::EXP_W-1:0] exp_r [scc_pkg::NUM_COEF];
  logic [scc_pkg::EXP_W-1:0] exp_nxt [scc_pkg::NUM_COEF];
  logic [2:0] comb_sel_r, comb_sel_nxt;
  logic [31:0] nom_per_r, nom_per_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  // datapath state
  scc_pkg::scc_cf_t cf_r, cf_nxt;
  logic [scc_pkg::CF_W-1:0] comb_r, comb_nxt;
  logic [scc_pkg::CF_W-1:0] poly_raw_r, poly_raw_nxt;
  logic [scc_pkg::CF_W-1:0] filt_out;
  logic filt_byp;
  scc_pkg::scc_meas_t meas;
  // pin synchronisers for the external measurement strobes and status
  logic [7:0] tv_s1_r, tv_s2_r;
  logic uns_s1_r, uns_s2_r;
  logic [11:0] widx;
  logic acc;

  // two-flop sync: first stage feeds only the second
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tv_s1_r <= 8'h00;
      tv_s2_r <= 8'h00;
      uns_s1_r <= 1'b1;
      uns_s2_r <= 1'b1;
    end else begin
      tv_s1_r <= i_tdc_valid;
      tv_s2_r <= tv_s1_r;
      uns_s1_r <= i_sys_unstable;
      uns_s2_r <= uns_s1_r;
    end
  end

  assign widx = i_paddr[13:2];
  assign acc = i_psel && i_penable && !pready_r;

  // apb slave: one wait state, answer in the cycle after penable rises
  always_comb begin
    aux_src_nxt = aux_src_r;
    cl_sel_nxt = cl_sel_r;
    cut_nxt = cut_r;
    c0_nxt = c0_r;
    sig_nxt = sig_r;
    exp_nxt = exp_r;
    comb_sel_nxt = comb_sel_r;
    nom_per_nxt = nom_per_r;
    prdata_nxt = prdata_r;
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    if (acc) begin
      prdata_nxt = scc_pkg::APB_ERR_DATA;
      if (widx == scc_pkg::IDX_AUX_SRC) begin
        if (i_pwrite) aux_src_nxt = i_pwdata[4:0];
        prdata_nxt = {27'h0, aux_src_r};
      end else if (widx == scc_pkg::IDX_CL_SEL) begin
        if (i_pwrite) cl_sel_nxt = i_pwdata[0];
        prdata_nxt = {31'h0, cl_sel_r};
      end else if (widx == scc_pkg::IDX_FILT_CUT) begin
        if (i_pwrite) cut_nxt = i_pwdata[2:0];
        prdata_nxt = {29'h0, cut_r};
      end else if (widx == scc_pkg::IDX_C0_LO) begin
        if (i_pwrite) c0_nxt[31:0] = i_pwdata;
        prdata_nxt = c0_r[31:0];
      end else if (widx == scc_pkg::IDX_C0_HI) begin
        if (i_pwrite) c0_nxt[39:32] = i_pwdata[7:0];
        prdata_nxt = {24'h0, c0_r[39:32]};
      end else if (widx >= scc_pkg::IDX_COEF_BASE && widx < scc_pkg::IDX_COEF_BASE + 12'(scc_pkg::NUM_COEF)) begin
        if (i_pwrite) begin
          sig_nxt[3'(widx - scc_pkg::IDX_COEF_BASE)] = i_pwdata[15:0];
          exp_nxt[3'(widx - scc_pkg::IDX_COEF_BASE)] = i_pwdata[23:16];
        end
        prdata_nxt = {8'h0, exp_r[3'(widx - scc_pkg::IDX_COEF_BASE)], sig_r[3'(widx - scc_pkg::IDX_COEF_BASE)]};
      end else if (widx == scc_pkg::IDX_COMB_SEL) begin
        if (i_pwrite) comb_sel_nxt = i_pwdata[2:0];
        prdata_nxt = {29'h0, comb_sel_r};
      end else if (widx == scc_pkg::IDX_NOM_PER) begin
        if (i_pwrite) nom_per_nxt = i_pwdata;
        prdata_nxt = nom_per_r;
      end else if (widx == scc_pkg::IDX_STATUS) begin
        prdata_nxt = {29'h0, !meas.valid, uns_s2_r, filt_byp};
      end else if (widx == scc_pkg::IDX_CF1) begin
        prdata_nxt = cf_r.cf1;
      end else if (widx == scc_pkg::IDX_CF3) begin
        prdata_nxt = cf_r.cf3;
      end else if (widx == scc_pkg::IDX_COMB) begin
        prdata_nxt = comb_r;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aux_src_r <= scc_pkg::AUX_SRC_RST;
      cl_sel_r <= scc_pkg::CL_SEL_RST;
      cut_r <= scc_pkg::FILT_RST;
      c0_r <= '0;
      sig_r <= '{default: '0};
      exp_r <= '{default: '0};
      comb_sel_r <= 3'h0;
      nom_per_r <= scc_pkg::NOM_PER_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      aux_src_r <= aux_src_nxt;
      cl_sel_r <= cl_sel_nxt;
      cut_r <= cut_nxt;
      c0_r <= c0_nxt;
      sig_r <= sig_nxt;
      exp_r <= exp_nxt;
      comb_sel_r <= comb_sel_nxt;
      nom_per_r <= nom_per_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // converter select: unused codes select nothing
  always_comb begin
    meas.src = aux_src_r;
    meas.valid = 1'b0;
    meas.period = 32'h0;
    case (aux_src_r)
      scc_pkg::SRC_REF_A, scc_pkg::SRC_REF_AC, scc_pkg::SRC_REF_B0, scc_pkg::SRC_REF_B1,
      scc_pkg::SRC_AUX0, scc_pkg::SRC_AUX1: begin
        meas.valid = tv_s2_r[aux_src_r[2:0]];
        meas.period = i_tdc_period[32*aux_src_r[2:0] +: 32];
      end
      default: meas.valid = 1'b0;
    endcase
  end

  // polynomial sum in q.45; each term c_k * t^k, with c_k = s*2^(e-15)
  function automatic logic signed [95:0] poly_eval(input logic signed [15:0] t);
    logic signed [95:0] acc_v;
    logic signed [95:0] tp;
    logic signed [95:0] term;
    int sh;
    acc_v = $signed({{56{c0_r[39]}}, c0_r});
    tp = 96'(t);
    for (int k = 0; k < scc_pkg::NUM_COEF; k++) begin
      term = $signed({{80{sig_r[k][15]}}, sig_r[k]}) * tp;
      sh = int'($signed(exp_r[k])) - scc_pkg::EXP_BIAS + scc_pkg::C0_SHIFT;
      if (sig_r[k] == 16'h0000) term = '0;
      else if (sh >= 0) term = term <<< sh;
      else term = term >>> (-sh);
      acc_v = acc_v + term;
      tp = 96'(tp * 96'(t));
    end
    return acc_v;
  endfunction

  // closed-loop and combined factors
  always_comb begin
    logic signed [63:0] err;
    logic [63:0] p12, p123;
    err = '0;
    cf_nxt = cf_r;
    poly_raw_nxt = scc_pkg::CF_ONE + scc_pkg::CF_W'(poly_eval(i_temp) >>> (scc_pkg::C0_SHIFT - scc_pkg::CF_FRAC));
    cf_nxt.cf1 = filt_out;
    cf_nxt.cf2 = cl_sel_r ? i_main_cf1 : i_main_cf0;
    if (meas.valid && meas.period != 32'h0) begin
      // nominal/measured relative to one, incoming factor removed
      err = $signed({32'h0, nom_per_r}) - $signed({32'h0, meas.period});
      cf_nxt.cf3 = scc_pkg::CF_ONE + 32'((err <<< scc_pkg::CF_FRAC) / $signed({32'h0, meas.period}));
      cf_nxt.cf3 = 32'((64'(cf_nxt.cf3) << scc_pkg::CF_FRAC) / 64'(i_aux_incoming == 32'h0 ? scc_pkg::CF_ONE
        : i_aux_incoming));
    end
    // index bits pick cf1, cf2, cf3; unselected factors act as one, but index zero gives zero
    p12 = 64'(comb_sel_r[0] ? cf_r.cf1 : scc_pkg::CF_ONE) * 64'(comb_sel_r[1] ? cf_r.cf2 : scc_pkg::CF_ONE);
    p123 = 64'(p12[61:30]) * 64'(comb_sel_r[2] ? cf_r.cf3 : scc_pkg::CF_ONE);
    comb_nxt = (comb_sel_r == 3'h0) ? '0 : p123[61:30];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cf_r <= '{cf1: scc_pkg::CF_ONE, cf2: scc_pkg::CF_ONE, cf3: scc_pkg::CF_ONE};
      comb_r <= '0;
      poly_raw_r <= scc_pkg::CF_ONE;
    end else begin
      cf_r <= cf_nxt;
      comb_r <= comb_nxt;
      poly_raw_r <= poly_raw_nxt;
    end
  end

  scc_lpf #(.W(scc_pkg::CF_W)) u_lpf (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_tick(i_temp_tick),
    .i_cut(cut_r),
    .i_unstable(uns_s2_r),
    .i_raw(poly_raw_r),
    .o_out(filt_out),
    .o_bypass(filt_byp)
  );

  // outputs straight from flops
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_comb_factor = comb_r;
  assign o_aux_src = aux_src_r;
  assign o_main_sel = cl_sel_r;

  property p_main_sel;
    @(posedge i_clk_sys) disable iff (i_rst) 1'b1 |=> cf_r.cf2 == ($past(cl_sel_r) ? $past(i_main_cf1) : $past(i_main_cf0));
  endproperty
  a_main_sel: assert property (p_main_sel) else $error("main factor from wrong channel");
  property p_hold_unused;
    @(posedge i_clk_sys) disable iff (i_rst) !meas.valid |=> $stable(cf_r.cf3);
  endproperty
  a_hold_unused: assert property (p_hold_unused) else $error("aux factor moved without measurement");
  property p_comb_zero;
    @(posedge i_clk_sys) disable iff (i_rst) comb_sel_r == 3'h0 |=> comb_r == '0;
  endproperty
  a_comb_zero: assert property (p_comb_zero) else $error("index zero not zero");
  property p_comb_one;
    @(posedge i_clk_sys) disable iff (i_rst) comb_sel_r == 3'h1 |=> comb_r == $past(cf_r.cf1);
  endproperty
  a_comb_one: assert property (p_comb_one) else $error("index one not first factor");
  property p_bypass;
    @(posedge i_clk_sys) disable iff (i_rst) uns_s2_r |=> filt_byp;
  endproperty
  a_bypass: assert property (p_bypass) else $error("filter not bypassed");
  sequence s_src_set;
    acc && i_pwrite && widx == scc_pkg::IDX_AUX_SRC;
  endsequence
  property p_src_write;
    @(posedge i_clk_sys) disable iff (i_rst) s_src_set |=> aux_src_r == $past(i_pwdata[4:0]);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source code not stored");
  property p_cut_write;
    @(posedge i_clk_sys) disable iff (i_rst) acc && i_pwrite && widx == scc_pkg::IDX_FILT_CUT
      |=> cut_r == $past(i_pwdata[2:0]);
  endproperty
  a_cut_write: assert property (p_cut_write) else $error("cutoff not stored");
  property p_nominal_match;
    @(posedge i_clk_sys) disable iff (i_rst) meas.valid && meas.period == nom_per_r && i_aux_incoming == scc_pkg::CF_ONE
      |=> cf_r.cf3 == scc_pkg::CF_ONE;
  endproperty
  a_nominal_match: assert property (p_nominal_match) else $error("matched period not unity");
endmodule

// ===== scc_ref_model.sv
// stable reference plus converter bank model feeding the aux loop
module scc_ref_model (
  input wire logic i_clk_sys,
  input wire logic i_on,
  input wire logic [2:0] i_slot,
  input wire logic [31:0] i_period,
  output logic [7:0] o_tdc_valid,
  output logic [255:0] o_tdc_period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cur_r = 32'h0000_0000;
  logic [31:0] junk_r = 32'h5a5a_5a5a;
  logic live_r = 1'b0;
  // valid drops for a cycle on a new period, so no moving value is sampled
  always @(posedge i_clk_sys) begin
    junk_r <= ~junk_r + 32'h0000_0001; // idle slots churn, never hold a value
    live_r <= i_on && (i_period == cur_r);
    cur_r <= i_period;
  end
  // only the selected converter reports a measured period
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      o_tdc_valid[k] = live_r && (i_slot == k[2:0]);
      o_tdc_period[32*k +: 32] = o_tdc_valid[k] ? cur_r : (junk_r ^ 32'(k));
    end
  end
endmodule

// ===== sysclk_compensation_control_test.sv
// self-checking bench for clock compensation control
module sysclk_compensation_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tick = 1'b0;
  logic unstable = 1'b0;
  logic [31:0] incoming = 32'h4000_0000; // unity, so a matched period must give exactly one
  logic [7:0] tdc_valid;
  logic [255:0] tdc_period;
  logic [31:0] comb;
  logic [4:0] aux_src;
  logic main_sel;
  logic ref_on = 1'b0;
  logic [2:0] ref_slot = 3'h0;
  logic [31:0] ref_period = 32'h0000_2710;
  int failures = 0;
  int tests_run = 0;
  // main channel factors are fixed sources, never fed from the combined output
  localparam logic [31:0] CF0 = 32'h4000_1000;
  localparam logic [31:0] CF1 = 32'h3fff_f000;
  localparam logic [31:0] F125 = 32'h5000_0000; // 1.25 in q2.30
  always #5 clk = ~clk;
  // filter advances every other cycle
  always @(posedge clk) tick <= ~tick;
  scc_top i_dut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_temp(16'sh0019), .i_temp_tick(tick), .i_sys_unstable(unstable), .i_main_cf0(CF0),
    .i_main_cf1(CF1), .i_tdc_valid(tdc_valid), .i_tdc_period(tdc_period), .i_aux_incoming(incoming),
    .o_comb_factor(comb), .o_aux_src(aux_src), .o_main_sel(main_sel));
  scc_ref_model i_ref (.i_clk_sys(clk), .i_on(ref_on), .i_slot(ref_slot), .i_period(ref_period),
    .o_tdc_valid(tdc_valid), .o_tdc_period(tdc_period));
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; outputs looked at mid-cycle, request released on the edge that sees pready
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      conclude();
    end
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  // bounded poll of a register field until it matches
  task automatic poll(input string what, input logic [11:0] idx, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, idx, 32'h0, r, e);
      n++;
    end while ((r & m) !== exp && n < 30);
    check(what, r & m, exp);
  endtask
  task automatic wait_comb(input logic [31:0] exp);
    int n;
    n = 0;
    while (comb !== exp && n < 30) begin
      @(negedge clk);
      n++;
    end
    check("comb", comb, exp);
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    check("aux_src pin", {27'h0, aux_src}, 32'h0);
    check("main_sel pin", {31'h0, main_sel}, 32'h0);
    check("comb idx0", comb, 32'h0);
    poll("aux src", scc_pkg::IDX_AUX_SRC, 32'hff, 32'h0);
    poll("cl sel", scc_pkg::IDX_CL_SEL, 32'hff, 32'h0);
    poll("nominal", scc_pkg::IDX_NOM_PER, 32'hffff_ffff, scc_pkg::NOM_PER_RST);
    apb(1'b0, 12'h2a0, 32'h0, r, e);
    check("unmapped data", r, scc_pkg::APB_ERR_DATA);
    check("unmapped err", {31'h0, e}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_coef();
    wr(scc_pkg::IDX_C0_HI, 32'hffff_ffff);
    poll("c0 high", scc_pkg::IDX_C0_HI, 32'hffff_ffff, 32'h0000_00ff);
    wr(scc_pkg::IDX_COEF_BASE, 32'hffff_ffff);
    poll("coef", scc_pkg::IDX_COEF_BASE, 32'hffff_ffff, 32'h00ff_ffff);
    wr(scc_pkg::IDX_COEF_BASE, 32'h0);
    wr(scc_pkg::IDX_C0_HI, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(scc_pkg::IDX_FILT_CUT, 32'(c));
      poll("cutoff", scc_pkg::IDX_FILT_CUT, 32'h7, 32'(c));
    end
    unstable <= 1'b1;
    poll("bypass on", scc_pkg::IDX_STATUS, 32'h3, 32'h3);
    unstable <= 1'b0;
    poll("unstable off", scc_pkg::IDX_STATUS, 32'h2, 32'h0);
    $display("test coef done");
  endtask
  task automatic t_main();
    wr(scc_pkg::IDX_COMB_SEL, 32'h2);
    wait_comb(CF0);
    wr(scc_pkg::IDX_CL_SEL, 32'h1);
    wait_comb(CF1);
    check("main_sel pin", {31'h0, main_sel}, 32'h1);
    wr(scc_pkg::IDX_COMB_SEL, 32'h1);
    wait_comb(scc_pkg::CF_ONE);
    poll("cf1", scc_pkg::IDX_CF1, 32'hffff_ffff, scc_pkg::CF_ONE);
    wr(scc_pkg::IDX_COMB_SEL, 32'h0);
    wait_comb(32'h0);
    $display("test main done");
  endtask
  task automatic t_aux();
    logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07};
    logic [31:0] exp;
    wr(scc_pkg::IDX_COMB_SEL, 32'h4);
    ref_on <= 1'b1;
    // alternate 8000 and 10000 so each code must move the factor
    for (int i = 0; i < 6; i++) begin
      exp = (i % 2 == 0) ? F125 : scc_pkg::CF_ONE;
      // move the source first so the old slot's stale strobe is never used
      wr(scc_pkg::IDX_AUX_SRC, {27'h0, codes[i]});
      ref_slot <= codes[i][2:0];
      ref_period <= (i % 2 == 0) ? 32'd8000 : 32'd10000;
      poll("cf3", scc_pkg::IDX_CF3, 32'hffff_ffff, exp);
      check("aux_src pin", {27'h0, aux_src}, {27'h0, codes[i]});
      wait_comb(exp);
    end
    wr(scc_pkg::IDX_AUX_SRC, 32'h4);
    ref_slot <= 3'h4;
    ref_period <= 32'd8000;
    poll("src idle", scc_pkg::IDX_STATUS, 32'h4, 32'h4);
    repeat (20) @(posedge clk);
    poll("cf3 held", scc_pkg::IDX_CF3, 32'hffff_ffff, scc_pkg::CF_ONE);
    wr(scc_pkg::IDX_AUX_SRC, 32'h6);
    ref_slot <= 3'h6;
    poll("cf3 aux0", scc_pkg::IDX_CF3, 32'hffff_ffff, F125);
    incoming <= F125;
    poll("cf3 residual", scc_pkg::IDX_CF3, 32'hffff_ffff, scc_pkg::CF_ONE);
    wr(scc_pkg::IDX_COMB_SEL, 32'h6);
    wait_comb(CF1);
    $display("test aux done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_coef();
    t_main();
    t_aux();
    conclude();
  end
endmodule
